// ### src/hwmip_pkg.sv
package hwmip_pkg;
  // host port offsets
  localparam logic [2:0] PORT_INDEX = 3'h5;
  localparam logic [2:0] PORT_DATA = 3'h6;
  // index map
  localparam logic [6:0] IDX_CONFIG = 7'h40;
  localparam logic [6:0] IDX_STAT1 = 7'h41;
  localparam logic [6:0] IDX_STAT2 = 7'h42;
  localparam logic [6:0] IDX_SMASK1 = 7'h43;
  localparam logic [6:0] IDX_SMASK2 = 7'h44;
  localparam logic [6:0] IDX_NMASK1 = 7'h45;
  localparam logic [6:0] IDX_NMASK2 = 7'h46;
  localparam logic [6:0] IDX_FANDIV = 7'h47;
  localparam logic [6:0] IDX_PARTID = 7'h49;
  localparam logic [6:0] IDX_PROPSEL = 7'h4c;
  localparam logic [6:0] IDX_FANBEEP = 7'h4d;
  localparam logic [6:0] IDX_BANKSEL = 7'h4e;
  localparam logic [6:0] IDX_MAKERID = 7'h4f;
  localparam logic [6:0] IDX_ALTCFG = 7'h52;
  localparam logic [6:0] IDX_STEP = 7'h5f;
  localparam logic [6:0] IDX_SCRATCH_END = 7'h1f;
  localparam logic [6:0] IDX_VALUE_END = 7'h7f;
  localparam logic [6:0] IDX_T2_LO = 7'h50;
  localparam logic [6:0] IDX_T2_HI = 7'h56;
  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h08;
  localparam logic [7:0] RST_NMASK2 = 8'h20;
  localparam logic [7:0] RST_FANDIV = 8'h50;
  localparam logic [7:0] RST_FANBEEP = 8'h15;
  localparam logic [7:0] RST_BANKSEL = 8'h80;
  localparam logic [7:0] RST_STEP = 8'h05;
  // arbitrary identity values
  localparam logic [7:0] PART_ID_VAL = 8'h5a;
  localparam logic [7:0] MAKER_ID_VAL = 8'ha5;
  // field positions
  localparam int CFG_START = 0;
  localparam int CFG_SMI_EN = 1;
  localparam int CFG_HALT = 3;
  localparam int CFG_INIT = 7;
  localparam int PROP_STEP = 1;
  localparam int ALT_LATCH = 2;
  localparam int BUSY_BIT = 7;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } hwmip_req_t;

  typedef enum logic [1:0] {
    OVT_IDLE,
    OVT_HIGH,
    OVT_COOLING
  } hwmip_ovt_t;
endpackage

// ### src/hwmip_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - comparator mode: alert while over limit, until below hysteresis
// - latched mode: over limit latches alert until sensor 2 read (bank 1, 50h-56h)
// - latched mode: after clear, fall below hysteresis relatches alert
// - latched mode: no reassert while above hysteresis after clear
// - step mode bit set: pulse alert entering next step level
// - step mode fires rising and falling, on every level crossing; no hysteresis
// - step size taken from granularity register 5Fh
// - step mode overrides comparator and latched modes
// - index port: pointer bits 6:0, busy bit 7, reset zero
// - busy set by index write or serial transaction
// - data port access clears busy set by index write
// - data port reads/writes the indexed byte
// - access at 41h/43h/45h moves pointer to paired register
// - scratch RAM access increments pointer, stopping at 1Fh
// - value RAM 60-7Fh increments, stops at 7Fh; 20-3Fh does not
// - config bit 7 restores defaults then clears itself
// - config bit 3 disables interrupt output and halts monitoring
// - config bit 1 enables interrupt output
// - config bit 0 starts monitoring, zero means standby
// - writing config zero leaves asserted interrupts untouched
module hwmip_top (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire hwmip_pkg::hwmip_req_t req_in,
  output logic [7:0] rdata_out,
  input wire logic serial_busy_in,
  input wire logic [8:0] temp2_in,
  input wire logic [8:0] over_limit_in,
  input wire logic [8:0] hysteresis_limit_in,
  input wire logic [7:0] status_one_in,
  input wire logic [7:0] status_two_in,
  output logic monitor_run_out,
  output logic over_temp_alert_n_out,
  output logic sysmgmt_interrupt_n_out
);

  ////////////////////////////////////////////////////////////////////
  logic serial_meta_r, serial_sync_r;
  logic [7:0] temp_meta_r, temp_sync_r;

  always_ff @(posedge clk_in) begin
    serial_meta_r <= serial_busy_in;
    serial_sync_r <= serial_meta_r;
    temp_meta_r <= temp2_in[8:1];
    temp_sync_r <= temp_meta_r;
  end

  function automatic logic in_range(input logic [6:0] v,
      input logic [6:0] lo, input logic [6:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////
  logic [6:0] index_r, index_nxt;
  logic busy_r;
  logic [7:0] config_r, smask1_r, smask2_r, nmask1_r, nmask2_r;
  logic [7:0] fandiv_r, propsel_r, fanbeep_r, banksel_r, altcfg_r;
  logic [7:0] step_r;
  logic [7:0] scratch_r [0:31];
  logic [7:0] value_r [0:31];
  logic [7:0] rdata_r;

  wire idx_wr = req_in.wr && req_in.addr == hwmip_pkg::PORT_INDEX;
  wire dat_wr = req_in.wr && req_in.addr == hwmip_pkg::PORT_DATA;
  wire dat_rd = req_in.rd && req_in.addr == hwmip_pkg::PORT_DATA;
  wire idx_rd = req_in.rd && req_in.addr == hwmip_pkg::PORT_INDEX;
  wire dat_acc = dat_wr || dat_rd;
  wire [3:0] bank = banksel_r[3:0];
  wire is_bank_reg = in_range(index_r, 7'h50, hwmip_pkg::IDX_STEP);
  wire is_scratch = in_range(index_r, 7'h00, hwmip_pkg::IDX_SCRATCH_END);
  wire is_value = index_r[5];
  wire is_value_inc = in_range(index_r, 7'h60, hwmip_pkg::IDX_VALUE_END);
  wire soft_init = config_r[hwmip_pkg::CFG_INIT];
  wire t2_read = dat_rd && bank == 4'h1 &&
      in_range(index_r, hwmip_pkg::IDX_T2_LO, hwmip_pkg::IDX_T2_HI);

  // pointer advance
  always_comb begin
    index_nxt = index_r;
    if (idx_wr)
      index_nxt = req_in.wdata[6:0];
    else if (dat_acc) begin
      if (index_r == hwmip_pkg::IDX_STAT1 ||
          index_r == hwmip_pkg::IDX_SMASK1 ||
          index_r == hwmip_pkg::IDX_NMASK1)
        index_nxt = index_r + 7'h01;
      else if (is_scratch && index_r != hwmip_pkg::IDX_SCRATCH_END)
        index_nxt = index_r + 7'h01;
      else if (is_value_inc && index_r != hwmip_pkg::IDX_VALUE_END)
        index_nxt = index_r + 7'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      index_r <= 7'h00;
      busy_r <= 1'b0;
    end else begin
      index_r <= index_nxt;
      if (idx_wr)
        busy_r <= 1'b1;
      else if (dat_acc)
        busy_r <= 1'b0;
    end
  end

  // register writes; soft init restores every register below, but not the index pointer or RAMs
  always_ff @(posedge clk_in) begin
    if (srst_in || soft_init) begin
      config_r <= hwmip_pkg::RST_CONFIG;
      smask1_r <= 8'h00;
      smask2_r <= 8'h00;
      nmask1_r <= 8'h00;
      nmask2_r <= hwmip_pkg::RST_NMASK2;
      fandiv_r <= hwmip_pkg::RST_FANDIV;
      propsel_r <= 8'h00;
      fanbeep_r <= hwmip_pkg::RST_FANBEEP;
      banksel_r <= hwmip_pkg::RST_BANKSEL;
      altcfg_r <= 8'h00;
      step_r <= hwmip_pkg::RST_STEP;
    end else if (dat_wr) begin
      unique case (index_r)
        hwmip_pkg::IDX_CONFIG: config_r <= req_in.wdata;
        hwmip_pkg::IDX_SMASK1: smask1_r <= req_in.wdata;
        hwmip_pkg::IDX_SMASK2: smask2_r <= req_in.wdata;
        hwmip_pkg::IDX_NMASK1: nmask1_r <= req_in.wdata;
        hwmip_pkg::IDX_NMASK2: nmask2_r <= req_in.wdata;
        hwmip_pkg::IDX_FANDIV: fandiv_r <= req_in.wdata;
        hwmip_pkg::IDX_PROPSEL: propsel_r <= req_in.wdata;
        hwmip_pkg::IDX_FANBEEP: fanbeep_r <= req_in.wdata;
        hwmip_pkg::IDX_BANKSEL: banksel_r <= req_in.wdata;
        hwmip_pkg::IDX_ALTCFG: begin
          if (bank == 4'h1 || bank == 4'h2)
            altcfg_r <= req_in.wdata;
        end
        hwmip_pkg::IDX_STEP: begin
          if (bank == 4'h0)
            step_r <= req_in.wdata;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (dat_wr && is_scratch)
      scratch_r[index_r[4:0]] <= req_in.wdata;
    if (dat_wr && is_value)
      value_r[index_r[4:0]] <= req_in.wdata;
  end

  // read mux
  logic [7:0] reg_rd;
  always_comb begin
    reg_rd = 8'h00;
    unique case (index_r)
      hwmip_pkg::IDX_CONFIG: reg_rd = config_r;
      hwmip_pkg::IDX_STAT1: reg_rd = status_one_in;
      hwmip_pkg::IDX_STAT2: reg_rd = status_two_in;
      hwmip_pkg::IDX_SMASK1: reg_rd = smask1_r;
      hwmip_pkg::IDX_SMASK2: reg_rd = smask2_r;
      hwmip_pkg::IDX_NMASK1: reg_rd = nmask1_r;
      hwmip_pkg::IDX_NMASK2: reg_rd = nmask2_r;
      hwmip_pkg::IDX_FANDIV: reg_rd = fandiv_r;
      hwmip_pkg::IDX_PARTID: reg_rd = hwmip_pkg::PART_ID_VAL;
      hwmip_pkg::IDX_PROPSEL: reg_rd = propsel_r;
      hwmip_pkg::IDX_FANBEEP: reg_rd = fanbeep_r;
      hwmip_pkg::IDX_BANKSEL: reg_rd = banksel_r;
      hwmip_pkg::IDX_MAKERID: reg_rd = hwmip_pkg::MAKER_ID_VAL;
      hwmip_pkg::IDX_ALTCFG:
        reg_rd = (bank == 4'h1 || bank == 4'h2) ? altcfg_r : 8'h00;
      hwmip_pkg::IDX_STEP: reg_rd = (bank == 4'h0) ? step_r : 8'h00;
      default: reg_rd = 8'h00;
    endcase
    if (is_scratch)
      reg_rd = scratch_r[index_r[4:0]];
    else if (is_value)
      reg_rd = value_r[index_r[4:0]];
    else if (is_bank_reg && index_r != hwmip_pkg::IDX_ALTCFG &&
        index_r != hwmip_pkg::IDX_STEP)
      reg_rd = 8'h00;
  end

  wire busy_flag = busy_r || serial_sync_r;

  always_ff @(posedge clk_in) begin
    if (srst_in)
      rdata_r <= 8'h00;
    else if (idx_rd)
      rdata_r <= {busy_flag, index_r};
    else if (dat_rd)
      rdata_r <= reg_rd;
  end
  assign rdata_out = rdata_r;

  ////////////////////////////////////////////////////////////////////
  // monitoring control
  wire running = config_r[hwmip_pkg::CFG_START] &&
      !config_r[hwmip_pkg::CFG_HALT];
  assign monitor_run_out = running;

  wire [7:0] t_now = temp_sync_r;
  wire over = $signed(t_now) > $signed(over_limit_in[8:1]);
  wire below_hyst = $signed(t_now) < $signed(hysteresis_limit_in[8:1]);
  wire step_mode = propsel_r[hwmip_pkg::PROP_STEP];
  wire latch_mode = altcfg_r[hwmip_pkg::ALT_LATCH];

  hwmip_pkg::hwmip_ovt_t ovt_r;
  logic alert_r, pulse_r;
  logic [7:0] level_r;
  wire [7:0] gran = (step_r == 8'h00) ? 8'h01 : step_r;
  wire [7:0] level_now = (t_now[7] ? 8'h00 : t_now) / gran;

  always_ff @(posedge clk_in) begin
    if (srst_in || soft_init) begin
      ovt_r <= hwmip_pkg::OVT_IDLE;
      alert_r <= 1'b0;
      pulse_r <= 1'b0;
      level_r <= 8'h00;
    end else if (running) begin
      pulse_r <= 1'b0;
      level_r <= level_now;
      if (level_now != level_r)
        pulse_r <= 1'b1;
      if (!latch_mode) begin
        ovt_r <= hwmip_pkg::OVT_IDLE;
        if (over)
          alert_r <= 1'b1;
        else if (below_hyst)
          alert_r <= 1'b0;
      end else begin
        unique case (ovt_r)
          hwmip_pkg::OVT_IDLE: if (over) begin
            alert_r <= 1'b1;
            ovt_r <= hwmip_pkg::OVT_HIGH;
          end
          hwmip_pkg::OVT_HIGH: if (t2_read) begin
            alert_r <= 1'b0;
            ovt_r <= hwmip_pkg::OVT_COOLING;
          end
          hwmip_pkg::OVT_COOLING: if (below_hyst) begin
            alert_r <= 1'b1;
            ovt_r <= hwmip_pkg::OVT_IDLE;
          end
        endcase
        // a new over-limit event wins over the read clear
        if (t2_read && ovt_r == hwmip_pkg::OVT_IDLE && !over)
          alert_r <= 1'b0;
      end
    end else begin
      pulse_r <= 1'b0;
      if (t2_read && latch_mode && alert_r)
        alert_r <= 1'b0;
    end
  end

  // step mode wins over other modes, outputs active low
  assign over_temp_alert_n_out = step_mode ? !pulse_r : !alert_r;

  wire [15:0] stat_unmasked = {status_two_in & ~smask2_r,
      status_one_in & ~smask1_r};
  logic smi_r;
  always_ff @(posedge clk_in) begin
    if (srst_in || soft_init)
      smi_r <= 1'b0;
    else if (|stat_unmasked)
      smi_r <= 1'b1;
    else if (dat_rd && (index_r == hwmip_pkg::IDX_STAT1 ||
        index_r == hwmip_pkg::IDX_STAT2))
      smi_r <= 1'b0;
  end
  // pin stays driven once raised, until the status read clears it
  logic smi_pin_r;
  wire smi_en = config_r[hwmip_pkg::CFG_SMI_EN];
  always_ff @(posedge clk_in) begin
    if (srst_in || soft_init)
      smi_pin_r <= 1'b0;
    else
      smi_pin_r <= smi_r && (smi_en || smi_pin_r);
  end
  assign sysmgmt_interrupt_n_out = !(smi_r && (smi_en || smi_pin_r) &&
      !config_r[hwmip_pkg::CFG_HALT]);

  ////////////////////////////////////////////////////////////////////
  sequence s_level_move;
    running && !soft_init && level_now != level_r;
  endsequence
  sequence s_latch_over;
    running && latch_mode && !soft_init &&
      ovt_r == hwmip_pkg::OVT_IDLE && over;
  endsequence

  a_busy_set: assert property (
    @(posedge clk_in) disable iff (srst_in)
    idx_wr |=> busy_r) else $error("busy not set");
  a_busy_clr: assert property (
    @(posedge clk_in) disable iff (srst_in)
    busy_r && dat_acc && !idx_wr |=> !busy_r)
    else $error("busy not cleared");
  a_busy_read: assert property (
    @(posedge clk_in) disable iff (srst_in)
    idx_rd |=> rdata_out == {$past(busy_flag), $past(index_r)})
    else $error("index port read");
  a_pair_inc: assert property (
    @(posedge clk_in) disable iff (srst_in)
    dat_acc && !idx_wr && index_r == hwmip_pkg::IDX_STAT1
    |=> index_r == hwmip_pkg::IDX_STAT2) else $error("pair inc");
  a_scratch_stop: assert property (
    @(posedge clk_in) disable iff (srst_in)
    dat_acc && !idx_wr && index_r == hwmip_pkg::IDX_SCRATCH_END
    |=> index_r == hwmip_pkg::IDX_SCRATCH_END) else $error("scratch");
  a_value_alias: assert property (
    @(posedge clk_in) disable iff (srst_in)
    dat_acc && !idx_wr && in_range(index_r, 7'h20, 7'h3f)
    |=> $stable(index_r)) else $error("alias moved");
  a_cmp_alert: assert property (
    @(posedge clk_in) disable iff (srst_in)
    running && !latch_mode && !soft_init && over |=> alert_r)
    else $error("cmp alert");
  a_hyst_clear: assert property (
    @(posedge clk_in) disable iff (srst_in)
    running && !latch_mode && !soft_init && !over && below_hyst
    |=> !alert_r) else $error("cmp release");
  a_latch_set: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_latch_over |=> alert_r && ovt_r == hwmip_pkg::OVT_HIGH)
    else $error("latch set");
  a_latch_hold: assert property (
    @(posedge clk_in) disable iff (srst_in)
    latch_mode && alert_r && !t2_read && !soft_init |=> alert_r)
    else $error("latch lost");
  a_latch_clear: assert property (
    @(posedge clk_in) disable iff (srst_in)
    running && latch_mode && !soft_init && t2_read &&
    ovt_r == hwmip_pkg::OVT_HIGH |=> !alert_r)
    else $error("latch clear");
  a_relatch: assert property (
    @(posedge clk_in) disable iff (srst_in)
    running && latch_mode && !soft_init && below_hyst &&
    ovt_r == hwmip_pkg::OVT_COOLING |=> alert_r)
    else $error("relatch");
  a_no_reassert: assert property (
    @(posedge clk_in) disable iff (srst_in)
    running && latch_mode && !soft_init && !below_hyst && !alert_r &&
    ovt_r == hwmip_pkg::OVT_COOLING |=> !alert_r)
    else $error("reassert");
  a_step_over: assert property (
    @(posedge clk_in) disable iff (srst_in)
    s_level_move ##1 step_mode |-> !over_temp_alert_n_out)
    else $error("step override");
  a_init_clear: assert property (
    @(posedge clk_in) disable iff (srst_in)
    dat_wr && index_r == hwmip_pkg::IDX_CONFIG && req_in.wdata[7]
    |=> soft_init ##1 !soft_init) else $error("init stuck");
  a_smi_hold: assert property (
    @(posedge clk_in) disable iff (srst_in)
    !sysmgmt_interrupt_n_out && !soft_init && dat_wr &&
    index_r == hwmip_pkg::IDX_CONFIG && req_in.wdata == 8'h00
    |=> !sysmgmt_interrupt_n_out) else $error("smi dropped");
endmodule

// ### verification/hwmip_host.sv
`timescale 1ns/1ps
module hwmip_host (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output hwmip_pkg::hwmip_req_t req_out
);
  initial req_out = '0;
  // one strobe cycle per access, changed at falling edges only
  task automatic acc(input logic r, input logic [2:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_in);
    req_out = '{rd: r, wr: !r, addr: a, wdata: d};
    @(negedge clk_in);
    q = rdata_in;
    // released data lines show the inverse, not the last value
    req_out = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_in, srst_in, serial_busy, alert_n, smi_n, run;
  logic [8:0] temp2, ovr, hys;
  logic [7:0] st1, st2, rdata, lows, n0, q;
  hwmip_pkg::hwmip_req_t req;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  hwmip_top dut (.clk_in(clk_in), .srst_in(srst_in), .req_in(req),
    .rdata_out(rdata), .serial_busy_in(serial_busy), .temp2_in(temp2),
    .over_limit_in(ovr), .hysteresis_limit_in(hys),
    .status_one_in(st1), .status_two_in(st2), .monitor_run_out(run),
    .over_temp_alert_n_out(alert_n), .sysmgmt_interrupt_n_out(smi_n));
  hwmip_host host (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial lows = 8'h00;
  always @(posedge clk_in) begin
    if (alert_n === 1'b0) lows <= lows + 8'h01;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim;
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, s);
    tests_run++;
    if (s !== e) begin
      $display("BAD %s exp %h got %h", n, e, s);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.acc(1'b0, a, d, x);
  endtask
  task automatic rd(input logic [2:0] a);
    host.acc(1'b1, a, 8'h00, q);
  endtask
  task automatic wi(input logic [6:0] i, input logic [7:0] d);
    wr(hwmip_pkg::PORT_INDEX, {1'b0, i});
    wr(hwmip_pkg::PORT_DATA, d);
  endtask
  task automatic cr(input logic [6:0] i, input logic [7:0] e);
    wr(hwmip_pkg::PORT_INDEX, {1'b0, i});
    rd(hwmip_pkg::PORT_DATA);
    chk("reg", e, q);
  endtask
  task automatic cp(input logic [7:0] e);
    rd(hwmip_pkg::PORT_INDEX);
    chk("index_port", e, q);
  endtask
  task automatic rst;
    @(negedge clk_in);
    srst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    srst_in = 1'b0;
  endtask
  task automatic tmp(input logic [7:0] c);
    temp2 = {c, 1'b0};
    repeat (8) @(negedge clk_in);
  endtask
  task automatic al(input logic e);
    repeat (4) @(negedge clk_in);
    chk("alert_n", {7'h00, e}, {7'h00, alert_n});
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    cp(8'h00);
    cr(7'h40, 8'h08);
    cr(7'h46, 8'h20);
    cr(7'h4d, 8'h15);
    cr(7'h4c, 8'h00);
    wi(7'h49, 8'h00);
    cr(7'h49, hwmip_pkg::PART_ID_VAL);
    chk("run_alert_smi", 8'h03, {5'h00, run, alert_n, smi_n});
  endtask
  task automatic t_busy;
    wr(hwmip_pkg::PORT_INDEX, 8'h43);
    cp(8'hc3);
    rd(hwmip_pkg::PORT_DATA);
    cp(8'h44);
    serial_busy = 1'b1;
    repeat (4) @(negedge clk_in);
    cp(8'hc4);
    serial_busy = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask
  task automatic t_pairs;
    st1 = 8'h12;
    st2 = 8'h34;
    for (int k = 1; k < 3; k++) begin
      wi(7'h41 + 7'(2 * k), 8'ha0 + 8'(k));
      wr(hwmip_pkg::PORT_DATA, 8'hb0 + 8'(k));
    end
    for (int k = 0; k < 3; k++) begin
      cr(7'h41 + 7'(2 * k), k == 0 ? 8'h12 : 8'ha0 + 8'(k));
      rd(hwmip_pkg::PORT_DATA);
      chk("paired", k == 0 ? 8'h34 : 8'hb0 + 8'(k), q);
    end
    st1 = 8'h00;
    st2 = 8'h00;
  endtask
  task automatic t_ram;
    wi(7'h1e, 8'h11);
    wr(hwmip_pkg::PORT_DATA, 8'h22);
    wr(hwmip_pkg::PORT_DATA, 8'h33);
    cp(8'h1f);
    cr(7'h1e, 8'h11);
    cr(7'h1f, 8'h33);
    wi(7'h7e, 8'h44);
    wr(hwmip_pkg::PORT_DATA, 8'h55);
    wr(hwmip_pkg::PORT_DATA, 8'h66);
    cp(8'h7f);
    cr(7'h3e, 8'h44);
    cr(7'h7f, 8'h66);
    wi(7'h3e, 8'h77);
    cp(8'h3e);
  endtask
  task automatic t_cfg;
    wi(7'h40, 8'h01);
    chk("run", 8'h01, {7'h00, run});
    wi(7'h40, 8'h09);
    chk("run", 8'h00, {7'h00, run});
    wi(7'h43, 8'hff);
    wi(7'h40, 8'h80);
    cr(7'h43, 8'h00);
    cr(7'h40, 8'h08);
  endtask
  task automatic t_cmp(input logic latch);
    rst;
    ovr = 9'h064;
    hys = 9'h05a;
    wi(7'h4e, 8'h01);
    wi(7'h52, {5'h00, latch, 2'h0});
    wi(7'h40, 8'h01);
    tmp(8'h3c);
    al(1'b0);
    tmp(8'h32);
    al(1'b0);
    if (latch) begin
      cr(7'h50, 8'h00);
      al(1'b1);
      tmp(8'h31);
      al(1'b1);
      tmp(8'h28);
      al(1'b0);
      wr(hwmip_pkg::PORT_INDEX, 8'h50);
      rd(hwmip_pkg::PORT_DATA);
      al(1'b1);
    end else begin
      tmp(8'h28);
      al(1'b1);
    end
  endtask
  task automatic t_step;
    rst;
    ovr = 9'h014;
    hys = 9'h010;
    wi(7'h5f, 8'h0a);
    tmp(8'h05);
    wi(7'h40, 8'h01);
    wi(7'h4c, 8'h02);
    n0 = lows;
    tmp(8'h0f);
    chk("pulses", n0 + 8'h01, lows);
    tmp(8'h0d);
    chk("pulses", n0 + 8'h01, lows);
    tmp(8'h19);
    chk("pulses", n0 + 8'h02, lows);
    tmp(8'h0f);
    chk("pulses", n0 + 8'h03, lows);
  endtask
  task automatic t_smi;
    rst;
    wi(7'h40, 8'h01);
    st1 = 8'h01;
    repeat (6) @(negedge clk_in);
    chk("smi_n", 8'h01, {7'h00, smi_n});
    st1 = 8'h00;
    cr(7'h41, 8'h00);
    cr(7'h42, 8'h00);
    wi(7'h40, 8'h03);
    st1 = 8'h01;
    repeat (6) @(negedge clk_in);
    chk("smi_n", 8'h00, {7'h00, smi_n});
    st1 = 8'h00;
    wi(7'h40, 8'h00);
    chk("smi_n", 8'h00, {7'h00, smi_n});
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    srst_in = 1'b1;
    serial_busy = 1'b0;
    temp2 = 9'h000;
    ovr = 9'h000;
    hys = 9'h000;
    st1 = 8'h00;
    st2 = 8'h00;
    repeat (3) @(negedge clk_in);
    srst_in = 1'b0;
    t_reset;
    t_busy;
    t_pairs;
    t_ram;
    t_cfg;
    t_cmp(1'b0);
    t_cmp(1'b1);
    t_step;
    t_smi;
    end_sim;
  end
endmodule
